//--- asmu_defs.svh
// Constants for the alarm status and mask unit
`ifndef ASMU_DEFS_SVH
`define ASMU_DEFS_SVH

// Configuration port geometry
`define ASMU_ADDR_W 12
`define ASMU_DATA_W 8

// Register byte addresses
`define ASMU_ADDR_SUMMARY 12'h2c0
`define ASMU_ADDR_STATUS 12'h2c1
`define ASMU_ADDR_MASK 12'h2c2
`define ASMU_ADDR_LANES_LO 12'h2c4
`define ASMU_ADDR_LANES_HI 12'h2c5

// Alarm status and mask bit positions
`define ASMU_BIT_FIFO 5
`define ASMU_BIT_PLL 4
`define ASMU_BIT_LINK 3
`define ASMU_BIT_REALIGN 2
`define ASMU_BIT_NCO 1
`define ASMU_BIT_CLK 0

// Field widths and reset values
`define ASMU_ALM_W 6
`define ASMU_LANES 16
`define ASMU_STATUS_RST 6'h3f
`define ASMU_MASK_RST 6'h3f
`define ASMU_LANES_RST 16'hffff
`define ASMU_BYTE_ZERO 8'h00

`endif

//--- asmu_pkg.sv
// Types shared by the alarm status and mask unit
`include "asmu_defs.svh"

package asmu_pkg;

    // Whole state of the top module, registered as one word
    typedef struct packed {
        logic [`ASMU_ALM_W-1:0] status;
        logic [`ASMU_ALM_W-1:0] mask;
        logic [`ASMU_LANES-1:0] lanes;
        logic link_en;
        logic [`ASMU_DATA_W-1:0] rdata;
        logic rvalid;
        logic alarm;
    } asmu_state_t;

    localparam asmu_state_t ASMU_STATE_RST = '{
        status: `ASMU_STATUS_RST,
        mask: `ASMU_MASK_RST,
        lanes: `ASMU_LANES_RST,
        link_en: 1'b0,
        rdata: `ASMU_BYTE_ZERO,
        rvalid: 1'b0,
        alarm: 1'b0
    };

endpackage

//--- asmu_cond.sv
// Set conditions of the six alarm sources
`timescale 1ns/1ps
`default_nettype none
`include "asmu_defs.svh"

module asmu_cond
    import asmu_pkg::*;
#(
    parameter int NCO_W = 32,
    parameter int DIV_W = 4
) (
    // Lane FIFO health
    input wire logic [`ASMU_LANES-1:0] lane_fifo_err,
    input wire logic [`ASMU_LANES-1:0] lane_active,
    // PLL and link
    input wire logic pll_locked,
    input wire logic serial_link_enable,
    input wire logic link_start,
    input wire logic mode_64b66b,
    input wire logic link_in_data_state,
    input wire logic link_realign,
    input wire logic sysref_realign,
    // Oscillators and dividers
    input wire logic nco_sync,
    input wire logic [NCO_W-1:0] nco_phase_a,
    input wire logic [NCO_W-1:0] nco_phase_b,
    input wire logic [DIV_W-1:0] div_state_a,
    input wire logic [DIV_W-1:0] div_state_b,
    // Per-source set requests
    output logic [`ASMU_ALM_W-1:0] set_vec
);

    // The comparison function is 64 bits wide, so wider words cannot be served
    if (NCO_W < 1 || NCO_W > 64 || DIV_W < 1 || DIV_W > 64) begin : g_bad_width
        $error("asmu_cond: NCO_W and DIV_W must lie in 1..64");
    end

    // Any bit of two channel copies disagrees
    function automatic logic differs(input logic [63:0] a, input logic [63:0] b);
        differs = (a != b);
    endfunction

    // One combinational term per status bit
    always_comb begin
        set_vec = '0;
        set_vec[`ASMU_BIT_FIFO] = |(lane_fifo_err & lane_active); // see RULE1
        set_vec[`ASMU_BIT_PLL] = !pll_locked; // see RULE3
        // 8b/10b: enabled but not sending data; 64b/66b: start-up or realign
        set_vec[`ASMU_BIT_LINK] = mode_64b66b ? (link_start | link_realign) // see RULE5
            : (serial_link_enable & !link_in_data_state); // see RULE4
        set_vec[`ASMU_BIT_REALIGN] = sysref_realign; // see RULE6
        set_vec[`ASMU_BIT_NCO] = !serial_link_enable | nco_sync // see RULE7
            | differs(64'(nco_phase_a), 64'(nco_phase_b));
        // Divider check stays live even with the link off
        set_vec[`ASMU_BIT_CLK] = differs(64'(div_state_a), 64'(div_state_b)); // see RULE8 see RULE10
    end

endmodule
`default_nettype wire

//--- asmu_top.sv
// Alarm status, mask and per-lane FIFO alarm registers
// Contract
// RULE1: Any active lane FIFO overflow or underflow sets the FIFO alarm bit.
// RULE2: Status bits stay set until software writes one; zero leaves them.
// RULE3: PLL not locked sets the lock-loss alarm bit.
// RULE4: 8b/10b: link enabled but not in data state sets link alarm.
// RULE5: 64b/66b: link start-up or realignment sets the link alarm.
// RULE6: SYSREF realignment of internal clocks sets the realign alarm.
// RULE7: NCO disabled, synchronized or channel phase mismatch sets oscillator alarm.
// RULE8: Channel A and B clock divider mismatch sets the clock alarm.
// RULE9: Power-on or soft reset sets all six status bits to one.
// RULE10: With link disabled only the clock alarm must be meaningful.
// RULE11: Software clears all alarms after enabling the serial link.
// RULE12: Set mask bits keep matching status bits out of the summary.
// RULE13: Lane i overflow or underflow sets per-lane alarm bit i.
// RULE14: Write-one clears a lane bit; resets all ones; persistent fault resets.
// RULE15: Write-one to FIFO status bit clears all per-lane bits.
// RULE16: Read-only summary bit is set while any unmasked status bit set.
// RULE17: A set in the same cycle as a clear wins.
`timescale 1ns/1ps
`default_nettype none
`include "asmu_defs.svh"

module asmu_top
    import asmu_pkg::*;
#(
    parameter int NCO_W = 32,
    parameter int DIV_W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_reset,
    // Configuration port
    input wire logic cfg_wr_en,
    input wire logic cfg_rd_en,
    input wire logic [`ASMU_ADDR_W-1:0] cfg_addr,
    input wire logic [`ASMU_DATA_W-1:0] cfg_wdata,
    output logic [`ASMU_DATA_W-1:0] cfg_rdata,
    output logic cfg_rvalid,
    // Lane FIFO health
    input wire logic [`ASMU_LANES-1:0] lane_fifo_err,
    input wire logic [`ASMU_LANES-1:0] lane_active,
    // PLL and link
    input wire logic pll_locked,
    input wire logic serial_link_enable,
    input wire logic mode_64b66b,
    input wire logic link_in_data_state,
    input wire logic link_realign,
    input wire logic sysref_realign,
    // Oscillators and dividers
    input wire logic nco_sync,
    input wire logic [NCO_W-1:0] nco_phase_a,
    input wire logic [NCO_W-1:0] nco_phase_b,
    input wire logic [DIV_W-1:0] div_state_a,
    input wire logic [DIV_W-1:0] div_state_b,
    // Hardware alarm output
    output logic alarm_out
);

    // Phase and divider words pass through a 64-bit compare, so wider ones are refused
    if (NCO_W < 1 || NCO_W > 64) begin : g_bad_nco
        $error("asmu_top: NCO_W must lie in 1..64");
    end
    if (DIV_W < 1 || DIV_W > 64) begin : g_bad_div
        $error("asmu_top: DIV_W must lie in 1..64");
    end

    asmu_state_t st_q;
    asmu_state_t st_d;
    logic [`ASMU_ALM_W-1:0] set_vec;
    logic [`ASMU_ALM_W-1:0] stat_clr;
    logic [`ASMU_LANES-1:0] lane_clr;
    logic [`ASMU_ALM_W-1:0] keep_v;
    logic link_start;
    logic wr_status;

    // Strobe aimed at one register byte; the write decodes below use it, the read decode uses a case on cfg_addr
    function automatic logic hits(input logic en, input logic [`ASMU_ADDR_W-1:0] a,
        input logic [`ASMU_ADDR_W-1:0] target);
        hits = en && (a == target);
    endfunction

    // Start-up of the link seen as the enable rising
    assign link_start = serial_link_enable & !st_q.link_en;

    asmu_cond #(
        .NCO_W(NCO_W),
        .DIV_W(DIV_W)
    ) u_cond (
        .lane_fifo_err(lane_fifo_err),
        .lane_active(lane_active),
        .pll_locked(pll_locked),
        .serial_link_enable(serial_link_enable),
        .link_start(link_start),
        .mode_64b66b(mode_64b66b),
        .link_in_data_state(link_in_data_state),
        .link_realign(link_realign),
        .sysref_realign(sysref_realign),
        .nco_sync(nco_sync),
        .nco_phase_a(nco_phase_a),
        .nco_phase_b(nco_phase_b),
        .div_state_a(div_state_a),
        .div_state_b(div_state_b),
        .set_vec(set_vec)
    );

    // Write-one clear strobes decoded from the port
    always_comb begin
        wr_status = hits(cfg_wr_en, cfg_addr, `ASMU_ADDR_STATUS);
        stat_clr = wr_status ? cfg_wdata[`ASMU_ALM_W-1:0] : '0; // see RULE2
        lane_clr = '0;
        // Lane record is cleared a byte at a time, no atomic pairing
        if (hits(cfg_wr_en, cfg_addr, `ASMU_ADDR_LANES_LO)) begin
            lane_clr[`ASMU_DATA_W-1:0] = cfg_wdata; // see RULE14
        end
        if (hits(cfg_wr_en, cfg_addr, `ASMU_ADDR_LANES_HI)) begin
            lane_clr[`ASMU_LANES-1:`ASMU_DATA_W] = cfg_wdata;
        end
        // Clearing the FIFO summary empties the lane record too
        if (wr_status && cfg_wdata[`ASMU_BIT_FIFO]) begin
            lane_clr = '1; // see RULE15
        end
        // Surviving status bits, watched by the sticky check
        keep_v = st_q.status & ~stat_clr;
    end

    // Next state: sets are ORed after clears, so sets win
    always_comb begin
        st_d = st_q;
        st_d.link_en = serial_link_enable;
        st_d.status = (st_q.status & ~stat_clr) | set_vec; // see RULE2 see RULE17
        st_d.lanes = (st_q.lanes & ~lane_clr) | lane_fifo_err; // see RULE13 see RULE14
        // Mask is plain read-write storage
        if (hits(cfg_wr_en, cfg_addr, `ASMU_ADDR_MASK)) begin
            st_d.mask = cfg_wdata[`ASMU_ALM_W-1:0];
        end
        // Read data reflects the state before this edge
        st_d.rvalid = cfg_rd_en;
        st_d.rdata = `ASMU_BYTE_ZERO;
        if (cfg_rd_en) begin
            case (cfg_addr)
                `ASMU_ADDR_SUMMARY: st_d.rdata = {7'h00, st_q.alarm};
                `ASMU_ADDR_STATUS: st_d.rdata = {2'h0, st_q.status};
                `ASMU_ADDR_MASK: st_d.rdata = {2'h0, st_q.mask};
                `ASMU_ADDR_LANES_LO: st_d.rdata = st_q.lanes[`ASMU_DATA_W-1:0];
                `ASMU_ADDR_LANES_HI: st_d.rdata = st_q.lanes[`ASMU_LANES-1:`ASMU_DATA_W];
                default: st_d.rdata = `ASMU_BYTE_ZERO;
            endcase
        end
        // Summary follows the registered status and mask
        st_d.alarm = |(st_d.status & ~st_d.mask); // see RULE12 see RULE16
        // Soft reset behaves like the port reset for the registers
        if (soft_reset) begin
            st_d = ASMU_STATE_RST; // see RULE9
        end
    end

    // Single state register, synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= ASMU_STATE_RST; // see RULE9
        end else begin
            st_q <= st_d;
        end
    end

    assign cfg_rdata = st_q.rdata;
    assign cfg_rvalid = st_q.rvalid;
    assign alarm_out = st_q.alarm;

    // Checks on the alarm registers
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || soft_reset);

    fifo_alarm_set_a: assert property ( // see RULE1
        |(lane_fifo_err & lane_active) |=> st_q.status[`ASMU_BIT_FIFO])
        else $error("FIFO alarm not set after active lane fault");

    status_sticky_a: assert property ( // see RULE2
        1'b1 |=> ((st_q.status & $past(keep_v)) == $past(keep_v)))
        else $error("status bit dropped without write-one");

    lock_loss_set_a: assert property ( // see RULE3
        !pll_locked |=> st_q.status[`ASMU_BIT_PLL])
        else $error("lock-loss alarm not set while PLL unlocked");

    link_8b10b_a: assert property ( // see RULE4
        serial_link_enable && !mode_64b66b && !link_in_data_state |=> st_q.status[`ASMU_BIT_LINK])
        else $error("link alarm missing in 8b10b mode");

    link_64b66b_a: assert property ( // see RULE5
        mode_64b66b && (link_realign || link_start) |=> st_q.status[`ASMU_BIT_LINK])
        else $error("link alarm missing on 64b66b start or realign");

    realign_set_a: assert property ( // see RULE6
        sysref_realign |=> st_q.status[`ASMU_BIT_REALIGN])
        else $error("realign alarm not set");

    nco_set_a: assert property ( // see RULE7
        (nco_sync || !serial_link_enable || nco_phase_a != nco_phase_b) |=> st_q.status[`ASMU_BIT_NCO])
        else $error("oscillator alarm not set");

    clk_div_a: assert property ( // see RULE8
        div_state_a != div_state_b |=> st_q.status[`ASMU_BIT_CLK])
        else $error("divider mismatch alarm not set");

    reset_value_a: assert property (@(posedge clk) disable iff (1'b0) // see RULE9
        (!rst_n || soft_reset) |=> (st_q.status == `ASMU_STATUS_RST && st_q.lanes == `ASMU_LANES_RST))
        else $error("status or lanes not all ones after reset");

    summary_out_a: assert property ( // see RULE12 see RULE16
        alarm_out == |(st_q.status & ~st_q.mask))
        else $error("summary alarm disagrees with status and mask");

    lane_set_a: assert property ( // see RULE13 see RULE14
        1'b1 |=> ((st_q.lanes & $past(lane_fifo_err)) == $past(lane_fifo_err)))
        else $error("lane alarm not set after lane fault");

    lane_clear_all_a: assert property ( // see RULE15
        wr_status && cfg_wdata[`ASMU_BIT_FIFO] && lane_fifo_err == '0 |=> st_q.lanes == '0)
        else $error("FIFO status clear did not empty lane record");

    set_wins_a: assert property ( // see RULE17
        !pll_locked && stat_clr[`ASMU_BIT_PLL] |=> st_q.status[`ASMU_BIT_PLL])
        else $error("clear beat a simultaneous set");

    // Write-one clears and mask writes
    status_clear_a: assert property ( // see RULE2
        wr_status && cfg_wdata[`ASMU_BIT_CLK] && !set_vec[`ASMU_BIT_CLK] |=> !st_q.status[`ASMU_BIT_CLK])
        else $error("write-one did not clear the clock alarm");

    mask_write_a: assert property ( // see RULE12
        cfg_wr_en && cfg_addr == `ASMU_ADDR_MASK |=> st_q.mask == $past(cfg_wdata[`ASMU_ALM_W-1:0]))
        else $error("mask write did not land");

    masked_quiet_a: assert property ( // see RULE12
        st_q.mask == `ASMU_MASK_RST |-> !alarm_out)
        else $error("summary raised with every alarm masked");

    lane_low_clear_a: assert property ( // see RULE14
        cfg_wr_en && cfg_addr == `ASMU_ADDR_LANES_LO |=>
        (st_q.lanes[`ASMU_DATA_W-1:0] & $past(cfg_wdata) & ~$past(lane_fifo_err[`ASMU_DATA_W-1:0])) == '0)
        else $error("low lane byte not cleared by write-one");

    lane_high_clear_a: assert property ( // see RULE14
        cfg_wr_en && cfg_addr == `ASMU_ADDR_LANES_HI |=>
        (st_q.lanes[`ASMU_LANES-1:`ASMU_DATA_W] & $past(cfg_wdata)
        & ~$past(lane_fifo_err[`ASMU_LANES-1:`ASMU_DATA_W])) == '0)
        else $error("high lane byte not cleared by write-one");

    // Quiet sources must not raise their bits
    fifo_gate_a: assert property ( // see RULE1
        (lane_fifo_err & lane_active) == '0 && !st_q.status[`ASMU_BIT_FIFO] |=> !st_q.status[`ASMU_BIT_FIFO])
        else $error("FIFO alarm set without an active lane fault");

    lock_quiet_a: assert property ( // see RULE3
        pll_locked && !st_q.status[`ASMU_BIT_PLL] |=> !st_q.status[`ASMU_BIT_PLL])
        else $error("lock-loss alarm set while locked");

    link_quiet_a: assert property ( // see RULE4
        !mode_64b66b && (!serial_link_enable || link_in_data_state) && !st_q.status[`ASMU_BIT_LINK]
        |=> !st_q.status[`ASMU_BIT_LINK])
        else $error("link alarm set in data state");

    realign_quiet_a: assert property ( // see RULE6
        !sysref_realign && !st_q.status[`ASMU_BIT_REALIGN] |=> !st_q.status[`ASMU_BIT_REALIGN])
        else $error("realign alarm set without an event");

    nco_quiet_a: assert property ( // see RULE7
        serial_link_enable && !nco_sync && nco_phase_a == nco_phase_b && !st_q.status[`ASMU_BIT_NCO]
        |=> !st_q.status[`ASMU_BIT_NCO])
        else $error("oscillator alarm set without a cause");

    clk_quiet_a: assert property ( // see RULE8
        div_state_a == div_state_b && !st_q.status[`ASMU_BIT_CLK] |=> !st_q.status[`ASMU_BIT_CLK])
        else $error("divider alarm set with matching dividers");

    lane_rise_a: assert property ( // see RULE13
        1'b1 |=> (st_q.lanes & ~$past(st_q.lanes) & ~$past(lane_fifo_err)) == '0)
        else $error("lane alarm rose without a lane fault");

    // Read path answers exactly one cycle after the strobe
    summary_read_a: assert property ( // see RULE16
        cfg_rd_en && cfg_addr == `ASMU_ADDR_SUMMARY |=> cfg_rdata == 8'($past(alarm_out)))
        else $error("summary read disagrees with the alarm output");

    read_pulse_a: assert property (
        cfg_rd_en |=> cfg_rvalid)
        else $error("read not answered one cycle later");

    read_idle_a: assert property (
        !cfg_rd_en |=> !cfg_rvalid && cfg_rdata == '0)
        else $error("read data shown without a read");

    // Covers for the main scenarios
    summary_rise_c: cover property (!alarm_out ##1 alarm_out);
    status_cleared_c: cover property (wr_status ##1 st_q.status == '0);
    lane_fault_c: cover property (|lane_fifo_err ##1 cfg_rd_en && cfg_addr == `ASMU_ADDR_LANES_LO);
    set_clear_c: cover property (!pll_locked && stat_clr[`ASMU_BIT_PLL]);
    inactive_lane_c: cover property (|lane_fifo_err && (lane_fifo_err & lane_active) == '0);

endmodule
`default_nettype wire

//--- test_alarm_status_mask_unit.sv
// Self-checking testbench for the alarm status and mask unit
`timescale 1ns/1ps
`default_nettype none
`include "asmu_defs.svh"

module test_alarm_status_mask_unit;
    import asmu_pkg::*;

    logic clk, rst_n, soft_reset, cfg_wr_en, cfg_rd_en, cfg_rvalid, alarm_out;
    logic [`ASMU_ADDR_W-1:0] cfg_addr;
    logic [`ASMU_DATA_W-1:0] cfg_wdata, cfg_rdata;
    logic [`ASMU_LANES-1:0] lane_fifo_err, lane_active;
    logic pll_locked, serial_link_enable, mode_64b66b, link_in_data_state, link_realign, sysref_realign, nco_sync;
    logic [31:0] nco_phase_a, nco_phase_b;
    logic [3:0] div_state_a, div_state_b;
    int errors = 0;
    int checks = 0;

    asmu_top DUT (.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset), .cfg_wr_en(cfg_wr_en),
        .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .lane_fifo_err(lane_fifo_err), .lane_active(lane_active),
        .pll_locked(pll_locked), .serial_link_enable(serial_link_enable), .mode_64b66b(mode_64b66b),
        .link_in_data_state(link_in_data_state), .link_realign(link_realign),
        .sysref_realign(sysref_realign), .nco_sync(nco_sync), .nco_phase_a(nco_phase_a),
        .nco_phase_b(nco_phase_b), .div_state_a(div_state_a), .div_state_b(div_state_b),
        .alarm_out(alarm_out));

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Write one byte; returns just after the taking edge so effects have landed
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        cfg_wr_en <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr_en <= 1'b0;
        #1;
    endtask

    // Read one byte and compare it in the answer cycle
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        cfg_rd_en <= 1'b1;
        cfg_addr <= a;
        @(posedge clk);
        cfg_rd_en <= 1'b0;
        #1;
        chk(16'(cfg_rvalid), 16'h0001);
        chk(16'(cfg_rdata), 16'(exp));
    endtask

    // Drive or release the set condition of one status bit
    task automatic cond(input int i, input logic on);
        case (i)
            0: div_state_b <= on ? 4'h1 : 4'h0;
            1: nco_sync <= on;
            2: sysref_realign <= on;
            3: link_in_data_state <= !on;
            4: pll_locked <= !on;
            default: lane_fifo_err <= on ? 16'h0008 : 16'h0000;
        endcase
    endtask

    task automatic t_reset();
        rd_chk(`ASMU_ADDR_STATUS, 8'h3f);
        rd_chk(`ASMU_ADDR_MASK, 8'h3f);
        rd_chk(`ASMU_ADDR_LANES_LO, 8'hff);
        rd_chk(`ASMU_ADDR_LANES_HI, 8'hff);
        rd_chk(`ASMU_ADDR_SUMMARY, 8'h00);
        rd_chk(12'h2c3, 8'h00);
        wr(`ASMU_ADDR_LANES_LO, 8'hff);
        rd_chk(`ASMU_ADDR_LANES_LO, 8'h00);
        rd_chk(`ASMU_ADDR_LANES_HI, 8'hff);
        wr(`ASMU_ADDR_STATUS, 8'h00);
        rd_chk(`ASMU_ADDR_STATUS, 8'h3f);
        wr(`ASMU_ADDR_STATUS, 8'h3f);
        rd_chk(`ASMU_ADDR_STATUS, 8'h00);
        rd_chk(`ASMU_ADDR_LANES_HI, 8'h00);
    endtask

    // Each source sets only its own bit; unmasking it raises the summary
    task automatic t_sources();
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            cond(i, 1'b1);
            @(posedge clk);
            cond(i, 1'b0);
            rd_chk(`ASMU_ADDR_STATUS, 8'(1 << i));
            wr(`ASMU_ADDR_MASK, 8'(~(1 << i)) & 8'h3f);
            chk(16'(alarm_out), 16'h0001);
            rd_chk(`ASMU_ADDR_SUMMARY, 8'h01);
            wr(`ASMU_ADDR_MASK, 8'h3f);
            chk(16'(alarm_out), 16'h0000);
            wr(`ASMU_ADDR_STATUS, 8'(1 << i));
        end
    endtask

    task automatic t_wide();
        @(posedge clk);
        mode_64b66b <= 1'b1;
        link_in_data_state <= 1'b0;
        nco_phase_b <= 32'h0000_0001;
        @(posedge clk);
        nco_phase_b <= 32'h0000_0000;
        rd_chk(`ASMU_ADDR_STATUS, 8'h02);
        wr(`ASMU_ADDR_STATUS, 8'h3f);
        rd_chk(`ASMU_ADDR_STATUS, 8'h00);
        @(posedge clk);
        link_realign <= 1'b1;
        @(posedge clk);
        link_realign <= 1'b0;
        rd_chk(`ASMU_ADDR_STATUS, 8'h08);
        wr(`ASMU_ADDR_STATUS, 8'h3f);
        @(posedge clk);
        serial_link_enable <= 1'b0;
        div_state_b <= 4'h1;
        @(posedge clk);
        serial_link_enable <= 1'b1;
        div_state_b <= 4'h0;
        @(posedge clk);
        rd_chk(`ASMU_ADDR_STATUS, 8'h0b);
        @(posedge clk);
        mode_64b66b <= 1'b0;
        link_in_data_state <= 1'b1;
        wr(`ASMU_ADDR_STATUS, 8'h3f);
    endtask

    task automatic t_lanes();
        @(posedge clk);
        lane_active <= 16'hfdff;
        lane_fifo_err <= 16'h0200;
        @(posedge clk);
        rd_chk(`ASMU_ADDR_STATUS, 8'h00);
        rd_chk(`ASMU_ADDR_LANES_HI, 8'h02);
        wr(`ASMU_ADDR_LANES_HI, 8'h02);
        rd_chk(`ASMU_ADDR_LANES_HI, 8'h02);
        @(posedge clk);
        lane_fifo_err <= 16'h0000;
        wr(`ASMU_ADDR_LANES_HI, 8'h00);
        rd_chk(`ASMU_ADDR_LANES_HI, 8'h02);
        wr(`ASMU_ADDR_LANES_HI, 8'h02);
        rd_chk(`ASMU_ADDR_LANES_HI, 8'h00);
        // Lock loss and a FIFO fault held across their own clears
        @(posedge clk);
        lane_active <= 16'hffff;
        lane_fifo_err <= 16'h0108;
        pll_locked <= 1'b0;
        wr(`ASMU_ADDR_STATUS, 8'h30);
        rd_chk(`ASMU_ADDR_STATUS, 8'h30);
        rd_chk(`ASMU_ADDR_LANES_LO, 8'h08);
        @(posedge clk);
        lane_fifo_err <= 16'h0000;
        pll_locked <= 1'b1;
        wr(`ASMU_ADDR_STATUS, 8'h30);
        rd_chk(`ASMU_ADDR_STATUS, 8'h00);
        rd_chk(`ASMU_ADDR_LANES_LO, 8'h00);
        rd_chk(`ASMU_ADDR_LANES_HI, 8'h00);
        wr(`ASMU_ADDR_MASK, 8'h00);
        @(posedge clk);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        rd_chk(`ASMU_ADDR_STATUS, 8'h3f);
        rd_chk(`ASMU_ADDR_MASK, 8'h3f);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Hang guard: far beyond the under two hundred cycles the tests need
    initial begin
        #100000;
        errors++;
        results();
    end

    // Quiet sources, reset for three cycles, then the scenarios
    initial begin
        {rst_n, soft_reset, cfg_wr_en, cfg_rd_en, cfg_addr, cfg_wdata} = '0;
        {lane_fifo_err, mode_64b66b, link_realign, sysref_realign, nco_sync} = '0;
        {nco_phase_a, nco_phase_b, div_state_a, div_state_b} = '0;
        lane_active = 16'hffff;
        {pll_locked, serial_link_enable, link_in_data_state} = 3'b111;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_sources();
        t_wide();
        t_lanes();
        results();
    end
endmodule

`default_nettype wire
